/* File: verilog/rst_seq_pkg.sv */
/*
 * Shared constants and carrier types for the reset sequencer and supply monitor.
 * Assumes a 100 MHz CPU clock and an AXI4-Lite register bus with 32-bit data.
 */
package rst_seq_pkg;

	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned DELAY_SHORT_CYC  = 256;
	localparam int unsigned DELAY_LONG_CYC   = 4096;
	localparam int unsigned FETCH_CYC        = 2;
	// Minimum output pulse on a watchdog reset; a least time rounds up.
	localparam int unsigned WDG_PULSE_MIN_NS = 2000;
	localparam int unsigned WDG_PULSE_CYC    = (WDG_PULSE_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

	localparam int unsigned AXI_ADDR_W = 8;
	localparam int unsigned AXI_DATA_W = 32;
	// The printed offset is not word aligned, so it is an index of 32-bit words.
	localparam int unsigned ICS_INDEX    = 5;
	localparam int unsigned STATUS_INDEX = 6;
	localparam logic [AXI_ADDR_W-1:0] ICS_ADDR    = AXI_ADDR_W'(ICS_INDEX * 4);
	localparam logic [AXI_ADDR_W-1:0] STATUS_ADDR = AXI_ADDR_W'(STATUS_INDEX * 4);

	localparam int unsigned WDG_FLAG_BIT  = 0;
	localparam int unsigned LVD_FLAG_BIT  = 4;
	localparam int unsigned WARN_FLAG_BIT = 5;
	localparam int unsigned WARN_IE_BIT   = 6;
	localparam logic [7:0]  ICS_RESET     = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PH_ACTIVE, PH_DELAY, PH_FETCH, PH_RUN} phase_t;
	typedef enum logic [1:0] {SEL_NONE, SEL_ICS, SEL_STATUS} reg_sel_t;

	typedef struct packed {
		logic                  awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic                  wvalid;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0]            wstrb;
		logic                  bready;
		logic                  arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic                  rready;
	} axil_req_t;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
	} axil_rsp_t;

endpackage

/* File: verilog/reset_sequencer.sv */
/*
 * Reset sequencer with low-supply reset, supply-warning interrupt and the
 * integrity control/status register behind an AXI4-Lite slave.
 * Assumes all inputs except the reset pin are synchronous to i_clk, the
 * option inputs are stable nonvolatile settings, and the pad resolves the
 * open-drain reset line from o_rst_pin_oe.
 */
// Our own choice: the AXI4-Lite interface to the registers.
module reset_sequencer #(
	parameter int unsigned DELAY_SHORT = rst_seq_pkg::DELAY_SHORT_CYC,
	parameter int unsigned DELAY_LONG  = rst_seq_pkg::DELAY_LONG_CYC,
	parameter int unsigned WDG_PULSE   = rst_seq_pkg::WDG_PULSE_CYC
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_rst_pin_n,
	output logic                       o_rst_pin_out,
	output logic                       o_rst_pin_oe,
	input  wire logic                  i_lvd_low,
	input  wire logic                  i_avd_comp,
	input  wire logic                  i_wdg_underflow,
	input  wire logic                  i_opt_lvd_enable,
	input  wire logic [1:0]            i_opt_lvd_level,
	input  wire logic                  i_opt_long_delay,
	input  wire logic                  i_halt,
	input  wire logic                  i_irq_ack,
	input  wire logic                  i_cc_irq_mask,
	output logic                       o_cpu_rst,
	output logic                       o_vector_fetch,
	output logic [15:0]                o_vector_addr,
	output logic                       o_avd_irq,
	output logic                       o_wake,
	output logic                       o_lvd_enable,
	output logic [1:0]                 o_lvd_level,
	input  wire rst_seq_pkg::axil_req_t i_axi,
	output rst_seq_pkg::axil_rsp_t     o_axi
);

	localparam int unsigned CNT_W = $clog2(DELAY_LONG + 1);

	typedef struct packed {
		rst_seq_pkg::phase_t                    phase;
		logic [CNT_W-1:0]                       cnt;
		logic [CNT_W-1:0]                       wdg_cnt;
		logic                                   lvd_en;
		logic                                   long_dly;
		logic [1:0]                             lvd_level;
		logic                                   ie;
		logic                                   supply_warning_flag;
		logic                                   low_supply_reset_flag;
		logic                                   watchdog_reset_flag;
		logic                                   pending;
		logic                                   drive;
		logic                                   pin_level;
		logic                                   cpu_rst;
		logic                                   fetch;
		logic [15:0]                            vec;
		logic                                   irq;
		logic                                   wake;
		logic                                   aw_full;
		logic                                   w_full;
		logic [rst_seq_pkg::AXI_ADDR_W-1:0]     waddr;
		logic [rst_seq_pkg::AXI_DATA_W-1:0]     wdata;
		logic [3:0]                             wstrb;
		rst_seq_pkg::axil_rsp_t                 axi;
	} seq_state_t;

	localparam seq_state_t ST_INIT = '{phase: rst_seq_pkg::PH_ACTIVE, drive: 1'b1,
		cpu_rst: 1'b1, default: '0};

	seq_state_t st;
	seq_state_t next_st;
	logic       ext_latch;

	function automatic rst_seq_pkg::reg_sel_t reg_sel(input logic [rst_seq_pkg::AXI_ADDR_W-1:0] a);
		if (a == rst_seq_pkg::ICS_ADDR)
			return rst_seq_pkg::SEL_ICS;
		else if (a == rst_seq_pkg::STATUS_ADDR)
			return rst_seq_pkg::SEL_STATUS;
		else
			return rst_seq_pkg::SEL_NONE;
	endfunction

	// Pin level is caught by an asynchronous set so a reset pulse is not lost
	// while the clock is stopped in halt; the sequencer consumes it once running.
	always_ff @(posedge i_clk or posedge i_sys_rst or negedge i_rst_pin_n) begin
		if (i_sys_rst)
			ext_latch <= 1'b0;
		else if (!i_rst_pin_n)
			ext_latch <= 1'b1;
		else if (st.phase != rst_seq_pkg::PH_RUN)
			ext_latch <= 1'b0;
	end

	always_comb begin
		logic                  lvd_cause;
		logic                  wdg_cause;
		logic                  any_cause;
		logic                  avd_now;
		logic                  ie_new;
		logic [CNT_W-1:0]      dly_last;
		logic [7:0]            ics_val;
		logic [7:0]            stat_val;
		rst_seq_pkg::reg_sel_t wsel;
		rst_seq_pkg::reg_sel_t rsel;
		next_st   = st;
		lvd_cause = st.lvd_en & i_lvd_low;
		wdg_cause = i_wdg_underflow | (st.wdg_cnt != '0);
		any_cause = lvd_cause | wdg_cause | (ext_latch & (st.phase == rst_seq_pkg::PH_RUN));
		avd_now   = st.lvd_en & i_avd_comp;
		ie_new    = 1'b0;
		dly_last  = st.long_dly ? CNT_W'(DELAY_LONG - 1) : CNT_W'(DELAY_SHORT - 1);
		ics_val   = {1'b0, st.ie, st.supply_warning_flag, st.low_supply_reset_flag, 3'b000, st.watchdog_reset_flag};
		stat_val  = {2'b00, st.lvd_level, st.long_dly, st.lvd_en, st.phase};
		wsel      = reg_sel(st.waddr);
		rsel      = reg_sel(i_axi.araddr);

		// Options are nonvolatile, so they are taken only while held in reset.
		if (st.phase != rst_seq_pkg::PH_RUN) begin
			next_st.lvd_en    = i_opt_lvd_enable;
			next_st.lvd_level = i_opt_lvd_level;
			next_st.long_dly  = i_opt_long_delay;
		end

		if (i_irq_ack)
			next_st.pending = 1'b0;

		// Register bus: response channels first, then address/data capture.
		if (st.axi.bvalid && i_axi.bready)
			next_st.axi.bvalid = 1'b0;
		if (st.axi.rvalid && i_axi.rready)
			next_st.axi.rvalid = 1'b0;
		if (i_axi.awvalid && st.axi.awready) begin
			next_st.aw_full = 1'b1;
			next_st.waddr   = i_axi.awaddr;
		end
		if (i_axi.wvalid && st.axi.wready) begin
			next_st.w_full = 1'b1;
			next_st.wdata  = i_axi.wdata;
			next_st.wstrb  = i_axi.wstrb;
		end
		if (st.aw_full && st.w_full && !st.axi.bvalid) begin
			next_st.aw_full   = 1'b0;
			next_st.w_full    = 1'b0;
			next_st.axi.bvalid = 1'b1;
			next_st.axi.bresp  = (wsel == rst_seq_pkg::SEL_NONE) ?
				rst_seq_pkg::RESP_SLVERR : rst_seq_pkg::RESP_OKAY;
			// A frozen register in halt still answers, but the write has no effect.
			if (wsel == rst_seq_pkg::SEL_ICS && st.wstrb[0] && !i_halt) begin
				ie_new     = st.wdata[rst_seq_pkg::WARN_IE_BIT];
				next_st.ie = ie_new;
				if (ie_new && !st.ie && st.supply_warning_flag && st.phase == rst_seq_pkg::PH_RUN)
					next_st.pending = 1'b1;
				if (!st.wdata[rst_seq_pkg::LVD_FLAG_BIT])
					next_st.low_supply_reset_flag = 1'b0;
				if (!st.wdata[rst_seq_pkg::WDG_FLAG_BIT])
					next_st.watchdog_reset_flag = 1'b0;
			end
		end
		if (i_axi.arvalid && st.axi.arready) begin
			next_st.axi.rvalid = 1'b1;
			next_st.axi.rresp  = (rsel == rst_seq_pkg::SEL_NONE) ?
				rst_seq_pkg::RESP_SLVERR : rst_seq_pkg::RESP_OKAY;
			unique case (rsel)
				rst_seq_pkg::SEL_ICS:    next_st.axi.rdata = {24'h000000, ics_val};
				rst_seq_pkg::SEL_STATUS: next_st.axi.rdata = {24'h000000, stat_val};
				rst_seq_pkg::SEL_NONE:   next_st.axi.rdata = '0;
			endcase
		end

		// Warning comparator copy and its change events, frozen during halt.
		if (!i_halt) begin
			next_st.supply_warning_flag = avd_now;
			if (st.phase == rst_seq_pkg::PH_RUN && st.ie && avd_now != st.supply_warning_flag)
				next_st.pending = 1'b1;
		end

		// Hardware sets and clears of the cause flags win over a software write.
		if (lvd_cause) begin
			next_st.low_supply_reset_flag = 1'b1;
			next_st.watchdog_reset_flag = 1'b0;
		end else if (i_wdg_underflow) begin
			next_st.watchdog_reset_flag = 1'b1;
		end

		if (i_wdg_underflow)
			next_st.wdg_cnt = CNT_W'(WDG_PULSE - 1);
		else if (st.wdg_cnt != '0)
			next_st.wdg_cnt = st.wdg_cnt - CNT_W'(1);

		if (any_cause && st.phase != rst_seq_pkg::PH_ACTIVE) begin
			next_st.phase = rst_seq_pkg::PH_ACTIVE;
			next_st.cnt   = '0;
		end else begin
			unique case (st.phase)
				rst_seq_pkg::PH_ACTIVE: begin
					if (!lvd_cause && !wdg_cause) begin
						next_st.phase = rst_seq_pkg::PH_DELAY;
						next_st.cnt   = '0;
					end
				end
				rst_seq_pkg::PH_DELAY: begin
					if (st.cnt == dly_last) begin
						next_st.phase = rst_seq_pkg::PH_FETCH;
						next_st.cnt   = '0;
					end else begin
						next_st.cnt = st.cnt + CNT_W'(1);
					end
				end
				rst_seq_pkg::PH_FETCH: begin
					if (st.cnt == CNT_W'(rst_seq_pkg::FETCH_CYC - 1)) begin
						next_st.phase = rst_seq_pkg::PH_RUN;
						next_st.cnt   = '0;
					end else begin
						next_st.cnt = st.cnt + CNT_W'(1);
					end
				end
				rst_seq_pkg::PH_RUN: next_st.cnt = '0;
			endcase
		end

		// Any reset returns the register to its reset value apart from its flag bits.
		if (next_st.phase != rst_seq_pkg::PH_RUN) begin
			next_st.ie      = rst_seq_pkg::ICS_RESET[rst_seq_pkg::WARN_IE_BIT];
			next_st.pending = 1'b0;
		end
		if (!next_st.lvd_en)
			next_st.pending = 1'b0;

		next_st.drive     = (next_st.phase == rst_seq_pkg::PH_ACTIVE) ||
			(next_st.phase == rst_seq_pkg::PH_DELAY);
		next_st.pin_level = !next_st.drive;
		next_st.cpu_rst   = next_st.phase != rst_seq_pkg::PH_RUN;
		next_st.fetch     = next_st.phase == rst_seq_pkg::PH_FETCH;
		next_st.vec       = next_st.fetch ?
			{rst_seq_pkg::RESET_VECTOR_ADDR[15:1], next_st.cnt[0]} : 16'h0000;
		next_st.irq       = next_st.pending & next_st.ie & !i_cc_irq_mask;
		next_st.wake      = next_st.pending & next_st.ie & !i_halt;
		next_st.axi.awready = !next_st.aw_full && !next_st.axi.bvalid;
		next_st.axi.wready  = !next_st.w_full && !next_st.axi.bvalid;
		next_st.axi.arready = !next_st.axi.rvalid;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			st <= ST_INIT;
		else
			st <= next_st;
	end

	assign o_rst_pin_out  = st.pin_level;
	assign o_rst_pin_oe   = st.drive;
	assign o_cpu_rst      = st.cpu_rst;
	assign o_vector_fetch = st.fetch;
	assign o_vector_addr  = st.vec;
	assign o_avd_irq      = st.irq;
	assign o_wake         = st.wake;
	assign o_lvd_enable   = st.lvd_en;
	assign o_lvd_level    = st.lvd_level;
	assign o_axi          = st.axi;

	// Checking helpers: length of the last unbroken delay phase.
	logic [CNT_W-1:0] dly_run;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			dly_run <= '0;
		else if (st.phase == rst_seq_pkg::PH_DELAY)
			dly_run <= dly_run + CNT_W'(1);
		else
			dly_run <= '0;
	end

	// Causes that send the sequencer back to the active phase on the next edge. The pin
	// latch stays out: it is still set in the first fetch cycle after every reset.
	logic any_reassert;
	assign any_reassert = i_wdg_underflow | (st.lvd_en & i_lvd_low) | (st.wdg_cnt != '0);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	line_low_delay_a: assert property (
		st.phase == rst_seq_pkg::PH_DELAY |-> o_rst_pin_oe && !o_rst_pin_out)
		else $error("reset line released during delay");
	vector_order_a: assert property (
		$rose(o_vector_fetch) && !any_reassert |->
		o_vector_addr == 16'hfffe ##1 o_vector_addr == 16'hffff)
		else $error("vector addresses out of order");
	phase_order_a: assert property (
		$rose(o_vector_fetch) |-> $past(st.phase) == rst_seq_pkg::PH_DELAY)
		else $error("fetch entered without delay phase");
	fetch_two_a: assert property (
		$rose(o_vector_fetch) && !any_reassert |=> o_vector_fetch ##1 !o_vector_fetch)
		else $error("vector fetch not two cycles");
	delay_len_a: assert property (
		$rose(o_vector_fetch) |-> dly_run == (st.long_dly ? CNT_W'(DELAY_LONG) :
			CNT_W'(DELAY_SHORT)))
		else $error("delay length wrong");
	wdg_drive_a: assert property (
		i_wdg_underflow || st.wdg_cnt != '0 |=> o_rst_pin_oe && !o_rst_pin_out && o_cpu_rst)
		else $error("watchdog pulse too short");
	lvd_hold_a: assert property (
		st.lvd_en && i_lvd_low |=> o_rst_pin_oe && o_cpu_rst)
		else $error("low supply did not hold reset");
	warn_copy_a: assert property (
		!$past(i_halt) |-> st.supply_warning_flag == ($past(st.lvd_en) && $past(i_avd_comp)))
		else $error("warning flag not a live copy");
	toggle_post_a: assert property (
		st.phase == rst_seq_pkg::PH_RUN && st.ie && !i_halt && st.lvd_en &&
		(st.lvd_en && i_avd_comp) != st.supply_warning_flag && !any_reassert && !ext_latch |=> st.pending)
		else $error("flag change did not post interrupt");
	irq_gate_a: assert property (
		o_avd_irq |-> !$past(i_cc_irq_mask) && st.pending && st.ie)
		else $error("interrupt passed the mask");
	reset_quiet_a: assert property (
		st.phase != rst_seq_pkg::PH_RUN |-> !st.pending && !o_avd_irq ##1 !st.pending)
		else $error("interrupt pending during reset");
	lvd_flags_a: assert property (
		st.lvd_en && i_lvd_low |=> st.low_supply_reset_flag && !st.watchdog_reset_flag)
		else $error("low supply flags wrong");
	pin_catch_a: assert property (
		st.phase == rst_seq_pkg::PH_RUN && ext_latch |=> st.phase == rst_seq_pkg::PH_ACTIVE)
		else $error("latched pin low did not start reset");
	opt_pass_a: assert property (
		st.phase != rst_seq_pkg::PH_RUN |=> o_lvd_enable == $past(i_opt_lvd_enable) &&
		o_lvd_level == $past(i_opt_lvd_level))
		else $error("option not taken while in reset");
	warn_off_a: assert property (
		!st.lvd_en |-> !st.pending && !o_avd_irq && !o_wake)
		else $error("warning interrupt active with detector off");
	ack_clear_a: assert property (
		i_irq_ack && !(st.aw_full && st.w_full) &&
		(i_halt || st.supply_warning_flag == (st.lvd_en && i_avd_comp)) |=> !st.pending)
		else $error("acknowledge did not clear pending");
	wake_gate_a: assert property (
		o_wake |-> !$past(i_halt) && st.pending && st.ie)
		else $error("wake raised in halt or without request");
	halt_freeze_a: assert property (
		i_halt && st.phase == rst_seq_pkg::PH_RUN && !any_reassert && !ext_latch |=>
		$stable(st.supply_warning_flag) && $stable(st.ie))
		else $error("register changed in halt");
	lvd_keep_a: assert property (
		st.low_supply_reset_flag && !(st.aw_full && st.w_full) |=> st.low_supply_reset_flag)
		else $error("low supply flag lost without a write");
	wdg_set_a: assert property (
		i_wdg_underflow && !(st.lvd_en && i_lvd_low) |=> st.watchdog_reset_flag && o_cpu_rst)
		else $error("watchdog flag not set");
	read_zero_a: assert property (
		o_axi.rvalid |-> !o_axi.rdata[7] && o_axi.rdata[31:8] == '0)
		else $error("reserved read bits not zero");
	delay_restart_a: assert property (
		st.phase == rst_seq_pkg::PH_DELAY && any_reassert |=>
		st.phase == rst_seq_pkg::PH_ACTIVE && st.cnt == '0)
		else $error("delay not restarted by a new cause");

	seq_done_c: cover property ($fell(o_cpu_rst));
	wdg_reset_c: cover property (i_wdg_underflow ##[1:300] $fell(o_cpu_rst));
	warn_irq_c: cover property ($rose(o_avd_irq));
	pin_reset_c: cover property (st.phase == rst_seq_pkg::PH_RUN && ext_latch);
	restart_c: cover property (st.phase == rst_seq_pkg::PH_DELAY && any_reassert);

endmodule

/* File: test/reset_line_model.sv */
/*
 * Model of the board-side reset circuitry on the shared open-drain reset line.
 * Assumes the bench commands external pulls and the sequencer drives only low.
 */
module reset_line_model (
	input  wire logic i_pull_low,
	input  wire logic i_out,
	input  wire logic i_oe,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 100ps;
	// The weak pull-up wins only when nobody on the line pulls it low.
	assign o_line = !((i_oe && !i_out) || i_pull_low);
endmodule

/* File: test/tb_reset_sequencer.sv */
/*
 * Self-checking bench for the reset sequencer with small delay counts.
 * Assumes the register bus answers as AXI4-Lite and the reset line has a pull-up.
 */
module tb_reset_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned DS = 4;
	localparam int unsigned DL = 16;
	localparam int unsigned WP = 3;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    pull = 1'b0;
	logic                    rst_line;
	logic                    pin_out;
	logic                    pin_oe;
	logic                    lvd_low = 1'b0;
	logic                    comp = 1'b0;
	logic                    wdg = 1'b0;
	logic                    lvd_en = 1'b0;
	logic [1:0]              lvl = 2'h2;
	logic                    long_dly = 1'b0;
	logic                    halt = 1'b0;
	logic                    ack = 1'b0;
	logic                    mask = 1'b1;
	logic                    cpu_rst;
	logic                    fetch;
	logic [15:0]             vaddr;
	logic                    irq;
	logic                    wake;
	logic                    lvd_en_o;
	logic [1:0]              lvl_o;
	rst_seq_pkg::axil_req_t  req = '0;
	rst_seq_pkg::axil_rsp_t  rsp;
	int                      err_count = 0;
	int                      num_checks = 0;
	int                      cycles = 0;

	always #5 clk = !clk;

	reset_sequencer #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WDG_PULSE(WP)) u_reset_sequencer (
		.i_clk(clk), .i_sys_rst(rst), .i_rst_pin_n(rst_line), .o_rst_pin_out(pin_out),
		.o_rst_pin_oe(pin_oe), .i_lvd_low(lvd_low), .i_avd_comp(comp), .i_wdg_underflow(wdg),
		.i_opt_lvd_enable(lvd_en), .i_opt_lvd_level(lvl), .i_opt_long_delay(long_dly),
		.i_halt(halt), .i_irq_ack(ack), .i_cc_irq_mask(mask), .o_cpu_rst(cpu_rst),
		.o_vector_fetch(fetch), .o_vector_addr(vaddr), .o_avd_irq(irq), .o_wake(wake),
		.o_lvd_enable(lvd_en_o), .o_lvd_level(lvl_o), .i_axi(req), .o_axi(rsp));

	reset_line_model u_reset_line_model (
		.i_pull_low(pull), .i_out(pin_out), .i_oe(pin_oe), .o_line(rst_line));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hangs are cut here rather than in each wait loop.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (rsp.awready) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (rsp.wready) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!rsp.bvalid);
		chk(32'(rsp.bresp), 32'(rst_seq_pkg::RESP_OKAY), "bresp");
		req.bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(posedge clk); while (!rsp.arready);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(32'(r), 32'(rst_seq_pkg::RESP_OKAY), "rresp");
		chk(d, e, "read data");
	endtask

	// Waits for the vector fetch and checks its two addresses and the release.
	task automatic wait_fetch;
		do @(posedge clk); while (!fetch);
		chk(32'(vaddr), 32'h0000fffe, "first vector");
		@(posedge clk);
		chk(32'({fetch, vaddr}), 32'h0001ffff, "second vector");
		@(posedge clk);
		chk(32'({fetch, cpu_rst}), 32'h0, "run after fetch");
	endtask

	task automatic t_por;
		rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		wait_fetch();
		rchk(rst_seq_pkg::ICS_ADDR, 32'h0);
		rchk(rst_seq_pkg::STATUS_ADDR, 32'({lvl, long_dly, lvd_en, 2'h3}));
		chk(32'(lvl_o), 32'h2, "level out");
		begin
			logic [31:0] d;
			logic [1:0]  r;
			rd(8'h40, d, r);
			chk(32'(r), 32'(rst_seq_pkg::RESP_SLVERR), "unmapped resp");
			chk(d, 32'h0, "unmapped data");
		end
		comp <= 1'b1;
		cyc(4);
		rchk(rst_seq_pkg::ICS_ADDR, 32'({lvd_en, 5'h00}));
		chk(32'(irq), 32'h0, "irq with detector off");
		comp <= 1'b0;
		$display("test por done");
	endtask

	// Counts the cycles in which the line is driven low, up to the first fetch cycle.
	task automatic count_low(output int n);
		n = 0;
		do begin
			@(posedge clk);
			if (pin_oe === 1'b1 && pin_out === 1'b0) n++;
		end while (!fetch && n < 100);
	endtask

	task automatic t_wdg(input logic long_sel);
		int n;
		long_dly <= long_sel;
		wdg <= 1'b1;
		@(posedge clk);
		wdg <= 1'b0;
		count_low(n);
		chk(n, WP + (long_sel ? DL : DS), "line low cycles");
		@(posedge clk);
		@(posedge clk);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h01);
		wr(rst_seq_pkg::ICS_ADDR, 32'h0);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h0);
		$display("test watchdog done");
	endtask

	task automatic t_lvd;
		int n;
		lvd_en <= 1'b1;
		long_dly <= 1'b0;
		t_por();
		chk(32'(lvd_en_o), 32'h1, "enable out");
		wdg <= 1'b1;
		@(posedge clk);
		wdg <= 1'b0;
		wait_fetch();
		lvd_low <= 1'b1;
		cyc(2);
		repeat (10) begin
			@(posedge clk);
			chk(32'({pin_oe, pin_out, cpu_rst}), 32'h5, "held by low supply");
		end
		lvd_low <= 1'b0;
		cyc(3);
		lvd_low <= 1'b1;
		@(posedge clk);
		lvd_low <= 1'b0;
		count_low(n);
		chk(n, 1 + DS, "restarted delay");
		cyc(2);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h10);
		@(posedge clk);
		#2 pull = 1'b1;
		#3 pull = 1'b0;
		wait_fetch();
		rchk(rst_seq_pkg::ICS_ADDR, 32'h10);
		wr(rst_seq_pkg::ICS_ADDR, 32'hde);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h50);
		wr(rst_seq_pkg::ICS_ADDR, 32'h0);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h0);
		$display("test low supply done");
	endtask

	task automatic ack_irq;
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		cyc(3);
		chk(32'(irq), 32'h0, "irq after ack");
	endtask

	task automatic t_avd;
		mask <= 1'b0;
		wr(rst_seq_pkg::ICS_ADDR, 32'h40);
		cyc(3);
		chk(32'(irq), 32'h0, "no change no irq");
		comp <= 1'b1;
		cyc(4);
		chk(32'({irq, wake}), 32'h3, "irq on rise");
		rchk(rst_seq_pkg::ICS_ADDR, 32'h60);
		mask <= 1'b1;
		cyc(3);
		chk(32'(irq), 32'h0, "masked");
		mask <= 1'b0;
		ack_irq();
		comp <= 1'b0;
		cyc(4);
		chk(32'(irq), 32'h1, "irq on fall");
		ack_irq();
		wr(rst_seq_pkg::ICS_ADDR, 32'h0);
		comp <= 1'b1;
		cyc(4);
		chk(32'(irq), 32'h0, "disabled");
		wr(rst_seq_pkg::ICS_ADDR, 32'h40);
		cyc(3);
		chk(32'(irq), 32'h1, "irq on enable");
		halt <= 1'b1;
		comp <= 1'b0;
		cyc(4);
		chk(32'({irq, wake}), 32'h2, "no wake in halt");
		wr(rst_seq_pkg::ICS_ADDR, 32'h0);
		rchk(rst_seq_pkg::ICS_ADDR, 32'h60);
		halt <= 1'b0;
		cyc(2);
		chk(32'({irq, wake}), 32'h3, "wake after halt");
		ack_irq();
		$display("test warning done");
	endtask

	initial begin
		t_por();
		t_wdg(1'b0);
		t_wdg(1'b1);
		t_lvd();
		t_avd();
		stop_test();
	end
endmodule
